/* File: include/drg_defines.svh */
// register offsets, field positions and reset values for the display rotation / pin register slice
// assumes inclusion by the single design file only; the checker and bench use literal offsets
`ifndef DRG_DEFINES_SVH
`define DRG_DEFINES_SVH
`define DRG_OFF_PIN_DIR     16'hFFF8
`define DRG_OFF_PIN_STATUS  16'hFFF9
`define DRG_OFF_SCRATCH     16'hFFFA
`define DRG_OFF_ROTATION    16'hFFFB
`define DRG_OFF_STRIDE      16'hFFFC
`define DRG_OFF_TEST_A      16'hFFFE
`define DRG_OFF_TEST_B      16'hFFFF
`define DRG_OFF_CLK_CFG     16'hFFF0
`define DRG_OFF_HTIME       16'hFFE0
`define DRG_OFF_VTIME       16'hFFE4
`define DRG_OFF_MODE        16'hFFE8
`define DRG_OFF_STATE       16'hFFEC
`define DRG_ROT_EN_BIT      7
`define DRG_ROT_SEL_BIT     6
`define DRG_ROT_RSVD_BIT    2
`define DRG_CLK_HALF_BIT    4
`define DRG_MCLK_LAND_BIT   5
`define DRG_RESET_BYTE      8'h00
`define DRG_HDP_W           7
`define DRG_HORIZ_BLANK_PERIOD_W          5
`define DRG_VDP_W           10
`define DRG_VERT_BLANK_PERIOD_W          6
`define DRG_HORIZ_BLANK_PERIOD_ADD        5'h04
`define DRG_PIX_PER_CHAR    3
`define DRG_BYPASS_2BPP_0   4'h0
`define DRG_BYPASS_2BPP_1   4'h5
`define DRG_BYPASS_2BPP_2   4'hA
`define DRG_BYPASS_2BPP_3   4'hF
`endif

/* File: include/drg_pkg.sv */
// types for the register slice, which uses only drg_orient_t; the checker and bench do not import them
// assumes drg_defines.svh for numeric constants
package drg_pkg;
   typedef enum logic [1:0] {drg_bpp1, drg_bpp2, drg_bpp4, drg_bpp8} drg_bpp_t;
   typedef enum logic [1:0] {drg_landscape, drg_rot_default, drg_rot_alternate} drg_orient_t;
   typedef enum logic [1:0] {drg_h_display, drg_h_blank} drg_hstate_t;
endpackage

/* File: design/drg_regs.sv */
// register slice: pins, scratch, rotation, stride, clock dividers, timing generator, bypass output
// assumes an APB master on pclk; pins are asynchronous and synchronised here
`include "drg_defines.svh"
module drg_regs #(
   parameter int PINS = 5
) (
   // apb
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [15:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // general purpose pins
   input  wire logic [PINS-1:0]       general_pin_n_in,
   output logic      [PINS-1:0]       general_pin_n_out,
   output logic      [PINS-1:0]       general_pin_n_oe,
   // panel side
   input  wire logic                  panel_data_upper_active,
   input  wire logic [1:0]            pixel_in,
   output logic                       pixel_clk_en,
   output logic                       memory_clk_en,
   output logic                       rotation_enable,
   output logic                       rotation_method_select,
   output logic      [7:0]            rotated_line_stride,
   output logic                       display_active,
   output logic                       frame_start,
   output logic      [3:0]            panel_data_out,
   output logic                       frame_rate_shading
);
   logic [PINS-1:0]  pin_dir;
   logic [PINS-1:0]  pin_out;
   logic [PINS-1:0]  pin_s1;
   logic [PINS-1:0]  pin_s2;
   logic [7:0]       scratch_pad;
   logic [7:0]       rotation_mode_control;
   logic [7:0]       clk_cfg;
   logic [15:0]      htime;
   logic [15:0]      vtime;
   logic [7:0]       mode_cfg;
   logic [PINS-1:0]  dedicated;
   logic             wr;
   logic             rd;
   logic [31:0]      next_prdata;
   logic             hit;
   drg_pkg::drg_orient_t orient;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   assign pready = 1'b1;   // zero wait states
   // pins 4..1 become upper panel data when that panel mode is active
   assign dedicated = panel_data_upper_active ? {{(PINS-1){1'b1}}, 1'b0} : '0;

   // two-stage synchroniser on pin inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         pin_s1 <= general_pin_n_in;
         pin_s2 <= pin_s1;
      end
   end

   // pin direction and output registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_dir <= '0;
         pin_out <= '0;
      end else begin
         if (wr && paddr == `DRG_OFF_PIN_DIR)
            pin_dir <= pwdata[PINS-1:0];
         if (wr && paddr == `DRG_OFF_PIN_STATUS)
            pin_out <= pwdata[PINS-1:0];
      end
   end

   // pin drive per bit
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         assign general_pin_n_oe[g]  = pin_dir[g] && !dedicated[g];
         assign general_pin_n_out[g] = pin_out[g];
      end
   endgenerate

   // scratch, rotation, stride and own configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scratch_pad           <= `DRG_RESET_BYTE;
         rotation_mode_control <= `DRG_RESET_BYTE;
         rotated_line_stride   <= `DRG_RESET_BYTE;
         clk_cfg               <= `DRG_RESET_BYTE;
         htime                 <= '0;
         vtime                 <= '0;
         mode_cfg              <= `DRG_RESET_BYTE;
      end else if (wr) begin
         unique case (paddr)
            `DRG_OFF_SCRATCH:  scratch_pad <= pwdata[7:0];
            `DRG_OFF_ROTATION: rotation_mode_control <= pwdata[7:0];
            `DRG_OFF_STRIDE:   rotated_line_stride <= pwdata[7:0];
            `DRG_OFF_CLK_CFG:  clk_cfg <= pwdata[7:0];
            `DRG_OFF_HTIME:    htime <= pwdata[15:0];
            `DRG_OFF_VTIME:    vtime <= pwdata[15:0];
            `DRG_OFF_MODE:     mode_cfg <= pwdata[7:0];
            default: ;  // factory test offsets and others: writes dropped
         endcase
      end
   end

   // orientation decode
   assign rotation_enable        = rotation_mode_control[`DRG_ROT_EN_BIT];
   assign rotation_method_select = rotation_enable && rotation_mode_control[`DRG_ROT_SEL_BIT];
   always_comb begin
      if (!rotation_enable)
         orient = drg_pkg::drg_landscape;             // bit 6 ignored
      else if (rotation_method_select)
         orient = drg_pkg::drg_rot_alternate;
      else
         orient = drg_pkg::drg_rot_default;
   end

   // read mux
   always_comb begin
      next_prdata = '0;
      hit = 1'b1;
      unique case (paddr)
         `DRG_OFF_PIN_DIR:    next_prdata[PINS-1:0] = pin_dir;
         `DRG_OFF_PIN_STATUS: next_prdata[PINS-1:0] = (pin_dir & pin_out) | (~pin_dir & pin_s2);
         `DRG_OFF_SCRATCH:    next_prdata[7:0] = scratch_pad;
         `DRG_OFF_ROTATION:   next_prdata[7:0] = rotation_mode_control;
         `DRG_OFF_STRIDE:     next_prdata[7:0] = rotated_line_stride;
         `DRG_OFF_TEST_A:     next_prdata = '0;
         `DRG_OFF_TEST_B:     next_prdata = '0;
         `DRG_OFF_CLK_CFG:    next_prdata[7:0] = clk_cfg;
         `DRG_OFF_HTIME:      next_prdata[15:0] = htime;
         `DRG_OFF_VTIME:      next_prdata[15:0] = vtime;
         `DRG_OFF_MODE:       next_prdata[7:0] = mode_cfg;
         `DRG_OFF_STATE:      next_prdata[3:0] = {display_active, frame_rate_shading, orient};
         default:             hit = 1'b0;
      endcase
   end
   assign prdata  = next_prdata;
   assign pslverr = psel && penable && !hit;

   // clock dividers: CLK source, then pixel / memory enables
   logic       clk_half;
   logic [2:0] div_cnt;
   logic [3:0] pix_mask;
   logic [3:0] mem_mask;
   logic       clk_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clk_half <= 1'b0;
      else
         clk_half <= ~clk_half;
   end
   assign clk_tick = clk_cfg[`DRG_CLK_HALF_BIT] ? clk_half : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         div_cnt <= '0;
      else if (clk_tick)
         div_cnt <= div_cnt + 3'h1;
   end
   // divide ratio as a mask of low count bits that must be zero
   always_comb begin
      pix_mask = 4'h0;
      mem_mask = 4'h0;
      unique case (orient)
         drg_pkg::drg_landscape: begin
            pix_mask = 4'h0;
            mem_mask = clk_cfg[`DRG_MCLK_LAND_BIT] ? 4'h1 : 4'h0;
         end
         drg_pkg::drg_rot_default: begin
            unique case (rotation_mode_control[1:0])
               2'h0: pix_mask = 4'h0;
               2'h1: pix_mask = 4'h1;
               2'h2: pix_mask = 4'h3;
               2'h3: pix_mask = 4'h7;
            endcase
            mem_mask = pix_mask;
         end
         drg_pkg::drg_rot_alternate: begin
            unique case (rotation_mode_control[1:0])
               2'h0, 2'h1: begin pix_mask = 4'h1; mem_mask = 4'h0; end
               2'h2:       begin pix_mask = 4'h3; mem_mask = 4'h1; end
               2'h3:       begin pix_mask = 4'h7; mem_mask = 4'h3; end
            endcase
         end
         default: ;
      endcase
   end
   assign pixel_clk_en  = clk_tick && (({1'b0, div_cnt} & pix_mask) == 4'h0);
   assign memory_clk_en = clk_tick && (({1'b0, div_cnt} & mem_mask) == 4'h0);

   // timing generator in pixel clocks; widths hold the largest field values
   // (128 chars of 8 pixels plus 35 blank chars, doubled in dual panel) without wrap
   logic [11:0] hcnt;
   logic [10:0] vcnt;
   logic [10:0] h_disp;
   logic [10:0] h_total;
   logic [10:0] v_disp;
   logic [10:0] v_total;
   logic        dual_panel;
   assign dual_panel = mode_cfg[2];
   assign h_disp  = ({4'h0, htime[`DRG_HDP_W-1:0]} + 11'h1) << `DRG_PIX_PER_CHAR;
   assign h_total = h_disp
                  + (({6'h0, htime[8 +: `DRG_HORIZ_BLANK_PERIOD_W]} + {6'h0, `DRG_HORIZ_BLANK_PERIOD_ADD}) << `DRG_PIX_PER_CHAR);
   // dual panel: half the lines per half-frame, line period doubled
   assign v_disp  = dual_panel ? {1'b0, vtime[`DRG_VDP_W-1:1]} + 11'h1
                               : {1'b0, vtime[`DRG_VDP_W-1:0]} + 11'h1;
   assign v_total = v_disp + {5'h0, vtime[10 +: `DRG_VERT_BLANK_PERIOD_W]};
   logic [11:0] h_lim;
   assign h_lim = dual_panel ? {h_total, 1'b0} : {1'b0, h_total};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt <= '0;
         vcnt <= '0;
      end else if (pixel_clk_en) begin
         if (hcnt + 12'h1 >= h_lim) begin
            hcnt <= '0;
            vcnt <= (vcnt + 11'h1 >= v_total) ? 11'h0 : vcnt + 11'h1;
         end else
            hcnt <= hcnt + 12'h1;
      end
   end
   assign display_active = (vcnt < v_disp) && (hcnt < {1'b0, h_disp});
   assign frame_start    = pixel_clk_en && hcnt == 12'h0 && vcnt == 11'h0;

   // display data path; bypass bits in mode_cfg: [1:0] depth, [3] bypass
   logic bypass;
   assign bypass = mode_cfg[3];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         panel_data_out     <= 4'h0;
         frame_rate_shading <= 1'b0;
      end else begin
         frame_rate_shading <= !(bypass && mode_cfg[1:0] == 2'h0);
         if (bypass && mode_cfg[1:0] == 2'h0)
            panel_data_out <= {4{pixel_in[0]}};
         else if (bypass && mode_cfg[1:0] == 2'h1) begin
            unique case (pixel_in)
               2'h0: panel_data_out <= `DRG_BYPASS_2BPP_0;
               2'h1: panel_data_out <= `DRG_BYPASS_2BPP_1;
               2'h2: panel_data_out <= `DRG_BYPASS_2BPP_2;
               2'h3: panel_data_out <= `DRG_BYPASS_2BPP_3;
            endcase
         end else
            panel_data_out <= {2'h0, pixel_in};
      end
   end
endmodule

/* File: dv/drg_regs_checker.sv */
// checker for the register slice: register writes, read data and pin enables
// assumes it is bound onto drg_regs and sees one clock domain
module drg_regs_checker #(
   parameter int PINS = 5
) (
   // apb
   input wire logic            pclk, presetn, psel, penable, pwrite,
   input wire logic [15:0]     paddr,
   input wire logic [31:0]     pwdata, prdata,
   // pins and panel
   input wire logic [PINS-1:0] general_pin_n_out, general_pin_n_oe,
   input wire logic            panel_data_upper_active, rotation_enable, rotation_method_select, frame_start,
   input wire logic [7:0]      rotated_line_stride
);
   logic       wr, rd;
   logic [7:0] scr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write and read strobes
   assign wr = psel && penable && pwrite;
   assign rd = psel && !pwrite;
   // shadow of the scratch byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         scr <= 8'h00;
      else if (wr && paddr == 16'hFFFA)
         scr <= pwdata[7:0];
   end
   chk_scratch_back: assert property (rd && paddr == 16'hFFFA |-> prdata == {24'h000000, scr})
      else $error("scratch read differs from last write");
   chk_out_written: assert property (wr && paddr == 16'hFFF9 |=> general_pin_n_out == $past(pwdata[PINS-1:0]))
      else $error("pin output differs from written status");
   chk_rot_written: assert property (wr && paddr == 16'hFFFB |=> rotation_enable == $past(pwdata[7])
      && rotation_method_select == ($past(pwdata[7]) && $past(pwdata[6]))) else $error("rotation outputs wrong");
   chk_stride_written: assert property (wr && paddr == 16'hFFFC |=> rotated_line_stride == $past(pwdata[7:0]))
      else $error("stride output differs from write");
   chk_method_gated: assert property (rotation_method_select |-> rotation_enable)
      else $error("method select without rotation");
   chk_dedicated_off: assert property (panel_data_upper_active && $past(panel_data_upper_active)
      |-> general_pin_n_oe[PINS-1:1] == '0) else $error("dedicated pin driven");
   chk_test_zero: assert property (rd && (paddr == 16'hFFFE || paddr == 16'hFFFF) |-> prdata == '0)
      else $error("test register reads nonzero");
   chk_upper_zero: assert property (rd && paddr == 16'hFFF9 |-> prdata[31:PINS] == '0)
      else $error("unused status bits nonzero");
   chk_frame_pulse: assert property (frame_start |=> !frame_start [*8])
      else $error("frame start too close");
endmodule

bind drg_regs drg_regs_checker #(.PINS(PINS)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .general_pin_n_out, .general_pin_n_oe, .panel_data_upper_active, .rotation_enable,
   .rotation_method_select, .frame_start, .rotated_line_stride);

/* File: dv/drg_pin_model.sv */
// far-side pin model: resolves each pin from device drive and external source
// assumes the bench supplies the level of pins that the device leaves undriven
module drg_pin_model #(
   parameter int PINS = 5
) (
   // device side
   input  wire logic [PINS-1:0] pin_out, pin_oe,
   // external source and resolved level
   input  wire logic [PINS-1:0] ext_level,
   output logic      [PINS-1:0] pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // a driven pin shows the device value, an input pin the external one
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: dv/tb_drg_regs.sv */
// bench for the register slice: apb tasks, pins, clock dividers, frame timing, bypass output
// assumes drg_regs with five pins, pclk at 50 MHz
module tb_drg_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, panel_act = 0;
   logic        pready, pslverr, pix_en, mem_en, rot_en, rot_sel, disp, fstart, frs;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, q, seed = 32'h0000000A;
   logic [4:0]  pin_out, pin_oe, pin_lvl, ext = '0;
   logic [1:0]  pixel_in = '0;
   logic [7:0]  stride, r, s;
   logic [3:0]  pdo;
   int          error_cnt = 0, compares = 0, n, np, nm;
   always #10 pclk = ~pclk;
   drg_regs #(.PINS(5)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .general_pin_n_in(pin_lvl), .general_pin_n_out(pin_out), .general_pin_n_oe(pin_oe),
      .panel_data_upper_active(panel_act), .pixel_in, .pixel_clk_en(pix_en), .memory_clk_en(mem_en),
      .rotation_enable(rot_en), .rotation_method_select(rot_sel), .rotated_line_stride(stride),
      .display_active(disp), .frame_start(fstart), .panel_data_out(pdo), .frame_rate_shading(frs));
   drg_pin_model #(.PINS(5)) u_pins (.pin_out, .pin_oe, .ext_level(ext), .pin_level(pin_lvl));
   // xorshift source and expected divider ratios
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int pdiv(logic [7:0] v, logic h);
      return (v[7] ? ((v[6] && v[1:0] == 0) ? 2 : 1 << v[1:0]) : 1) << h;
   endfunction
   function automatic int mdiv(logic [7:0] v, logic h);
      return (v[7] ? (v[6] ? (v[1:0] == 0 ? 1 : 1 << (v[1:0] - 1)) : 1 << v[1:0]) : 1) << h;
   endfunction
   task automatic finish_test();
      $display("mismatches %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      error_cnt++;
      $display("wrong value at %0t: wait ran out", $time);
      finish_test();
   endtask
   task automatic wt(ref logic sig);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sig !== 1'b1 && n < 3000);
      if (sig !== 1'b1) tmo();
   endtask
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e = 1'b0);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      wt(pready);
      rd = prdata;
      chk(pslverr, e);
      psel <= 0;
      penable <= 0;
      #1;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
      apb(0, a, '0);
      chk(rd, e);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      for (int a = 16'hFFF8; a <= 16'hFFFC; a++) rdchk(16'(a), '0);
      repeat (8) begin
         r = 8'(rnd());
         s = ~r;
         apb(1, 16'hFFFA, 32'(r));
         apb(1, 16'hFFFC, 32'(s));
         rdchk(16'hFFFA, 32'(r));
         rdchk(16'hFFFC, 32'(s));
         chk(stride, s);
      end
      // mixed directions against random external levels
      repeat (6) begin
         q = rnd();
         ext <= q[14:10];
         apb(1, 16'hFFF8, 32'(q[4:0]));
         apb(1, 16'hFFF9, 32'hFFFFFFE0 | q[9:5]);
         chk(pin_oe, q[4:0]);
         chk(pin_out, q[9:5]);
         rdchk(16'hFFF9, (q[4:0] & q[9:5]) | (~q[4:0] & q[14:10]));
      end
      apb(1, 16'hFFF8, 32'h1F);
      panel_act <= 1;
      repeat (3) @(posedge pclk);
      #1 chk(pin_oe, 5'h01);
      panel_act <= 0;
      // every rotation mode and clock select, then landscape with halved source
      for (int i = 0; i < 10; i++) begin
         r = (i >= 8) ? 8'h01 : {1'b1, 1'(i >> 2), 4'h0, 2'(i)};
         apb(1, 16'hFFF0, (i == 9) ? 32'h10 : 32'h0);
         apb(1, 16'hFFFB, 32'(r));
         rdchk(16'hFFFB, 32'(r));
         chk({rot_en, rot_sel}, {r[7], r[7] & r[6]});
         apb(0, 16'hFFEC, '0);
         chk(rd[1:0], r[7] ? (r[6] ? 2 : 1) : 0);
         repeat (16) @(posedge pclk);
         np = 0;
         nm = 0;
         repeat (64) begin
            @(posedge pclk);
            np += pix_en;
            nm += mem_en;
         end
         chk(np, 64 / pdiv(r, i == 9));
         chk(nm, 64 / mdiv(r, i == 9));
      end
      // frame length, single then dual panel: line (0+1)*8 + (0+4)*8, lines 1+1 and 1
      apb(1, 16'hFFF0, '0);
      apb(1, 16'hFFFB, '0);
      apb(1, 16'hFFE0, '0);
      apb(1, 16'hFFE4, 32'h0401);
      for (int d = 0; d < 2; d++) begin
         apb(1, 16'hFFE8, d ? 32'h4 : 32'h0);
         wt(fstart);
         wt(fstart);
         wt(fstart);
         chk(n, d ? 2 * (8 + 32) * (2 / 2 + 1) : (8 + 32) * (2 + 1));
      end
      // bypass output, two bits then one bit per pixel
      apb(1, 16'hFFE0, 32'h7F);
      for (int k = 0; k < 6; k++) begin
         apb(1, 16'hFFE8, k < 4 ? 32'h9 : 32'h8);
         pixel_in <= 2'(k);
         wt(disp);
         repeat (3) @(posedge pclk);
         #1 chk(pdo, k < 4 ? k * 5 : (k - 4) * 15);
         chk(frs, k < 4);
      end
      apb(0, 16'hFFF4, '0, 1'b1);
      rdchk(16'hFFFE, '0);
      rdchk(16'hFFFF, '0);
      finish_test();
   end
endmodule
